// file: rtl/ttcu_timers.sv
`timescale 1ns/1ps
module ttcu_timers
  import ttcu_pkg::*;
#(
  parameter int unsigned MC_DIV = TTCU_MC_DIV_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       count_pin_zero,
  input  wire logic       count_pin_one,
  input  wire logic       count_pin_two,
  input  wire logic       ext_irq_pin_zero,
  input  wire logic       ext_irq_pin_one,
  input  wire logic       trigger_pin_two,
  output logic            overflow_flag_timer_zero,
  output logic            overflow_flag_timer_one,
  output logic            overflow_flag_two,
  output logic            trigger_flag_two,
  output logic            timer2_irq,
  output logic            t1_ovf_pulse,
  output logic            t2_ovf_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check
  if (MC_DIV < 2 || MC_DIV > 32)
  begin : g_bad_div
    $error("MC_DIV must lie between 2 and 32");
  end

  localparam logic [TTCU_MC_CNT_W-1:0] MC_LAST = TTCU_MC_CNT_W'(MC_DIV - 1);

  typedef struct packed {
    logic [TTCU_MC_CNT_W-1:0] mc_cnt;
    logic [7:0]               timer01_mode_select;
    logic [7:0]               run_flags;
    logic [7:0]               timer2_control;
    logic [7:0]               aux;
    logic [7:0]               timer_zero_low_byte;
    logic [7:0]               timer_zero_high_byte;
    logic [7:0]               timer_one_low_byte;
    logic [7:0]               timer_one_high_byte;
    logic [7:0]               count_low_byte_two;
    logic [7:0]               count_high_byte_two;
    logic [7:0]               capture_reload_low;
    logic [7:0]               capture_reload_high;
    logic                     pin0_q;
    logic                     pin1_q;
    logic                     pin2_q;
    logic                     trig_q;
    logic [7:0]               rdata;
    logic                     t1_ovf;
    logic                     t2_ovf;
  } ttcu_state_t;

  ttcu_state_t s_r;
  ttcu_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // One increment of timer 0 or 1; returns {overflow, high, low}
  function automatic logic [16:0] ttcu_step(input ttcu_mode_t mode,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    case (mode)
      TTCU_MODE_13BIT:
      begin
        r[4:0] = lo[4:0] + 5'h01;
        if (lo[4:0] == TTCU_PRESC_ONES)
        begin
          r[15:8] = hi + 8'h01;
          r[16]   = (hi == TTCU_BYTE_ONES);
        end
      end
      TTCU_MODE_16BIT:
      begin
        r[15:0] = {hi, lo} + 16'h0001;
        r[16]   = ({hi, lo} == TTCU_WORD_ONES);
      end
      TTCU_MODE_RELOAD:
      begin
        r[7:0] = (lo == TTCU_BYTE_ONES) ? hi : lo + 8'h01;
        r[16]  = (lo == TTCU_BYTE_ONES);
      end
      TTCU_MODE_SPLIT:
      begin
        r[7:0] = lo + 8'h01;
        r[16]  = (lo == TTCU_BYTE_ONES);
      end
      default:
      begin
        r = {1'b0, hi, lo};
      end
    endcase
    return r;
  endfunction

  function automatic logic ttcu_hit(input logic [3:0] a, input logic [3:0] b);
    return a == b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic        tick;
    logic        wr;
    ttcu_mode_t  mode0;
    ttcu_mode_t  mode1;
    logic        split0;
    logic        en0;
    logic        en1;
    logic        ev0;
    logic        ev1;
    logic        ev2;
    logic        inc0;
    logic        inc1;
    logic        inc0h;
    logic        inc2;
    logic [16:0] st0;
    logic [16:0] st1;
    logic        ovf0;
    logic        ovf1;
    logic        ovf0h;
    logic [7:0]  hi0;
    logic        baud;
    logic        trig_edge;
    logic        ext_ev;
    logic [15:0] cnt2;
    logic [15:0] cap;
    logic [15:0] cnt2_nxt;
    logic [15:0] cap_nxt;
    logic        set_tf2;
    logic        set_trigger_flag_two;
    logic        ovf2;
    logic        set_tf0;
    logic        set_tf1;

    s_nxt = s_r;
    wr    = reg_wr;
    tick  = (s_r.mc_cnt == MC_LAST);
    s_nxt.mc_cnt = tick ? '0 : s_r.mc_cnt + TTCU_MC_CNT_W'(1);

    // Pins are sampled once per machine cycle; an edge is high then low
    if (tick)
    begin
      s_nxt.pin0_q = count_pin_zero;
      s_nxt.pin1_q = count_pin_one;
      s_nxt.pin2_q = count_pin_two;
      s_nxt.trig_q = trigger_pin_two;
    end

    mode0  = ttcu_mode_t'(s_r.timer01_mode_select[TTCU_MS_MODE0 +: 2]);
    mode1  = ttcu_mode_t'(s_r.timer01_mode_select[TTCU_MS_MODE1 +: 2]);
    split0 = (mode0 == TTCU_MODE_SPLIT);

    ////////////////////////////////////////////////////////////////////////
    // Timers 0 and 1
    en0 = s_r.run_flags[TTCU_RF_TR0] &
          (~s_r.timer01_mode_select[TTCU_MS_GATE0] | ext_irq_pin_zero);
    en1 = s_r.run_flags[TTCU_RF_TR1] &
          (~s_r.timer01_mode_select[TTCU_MS_GATE1] | ext_irq_pin_one) &
          (mode1 != TTCU_MODE_SPLIT);
    ev0 = s_r.timer01_mode_select[TTCU_MS_CT0] ?
          (s_r.pin0_q & ~count_pin_zero) : 1'b1;
    ev1 = s_r.timer01_mode_select[TTCU_MS_CT1] ?
          (s_r.pin1_q & ~count_pin_one) : 1'b1;
    inc0  = tick & en0 & ev0;
    inc1  = tick & en1 & ev1;
    inc0h = tick & split0 & s_r.run_flags[TTCU_RF_TR1];

    st0 = ttcu_step(mode0, s_r.timer_zero_low_byte, s_r.timer_zero_high_byte);
    st1 = ttcu_step(mode1, s_r.timer_one_low_byte, s_r.timer_one_high_byte);
    ovf0  = inc0 & st0[16];
    ovf1  = inc1 & st1[16];
    ovf0h = inc0h & (s_r.timer_zero_high_byte == TTCU_BYTE_ONES);
    hi0   = split0 ? s_r.timer_zero_high_byte + 8'h01 : st0[15:8];

    if (inc0)
    begin
      s_nxt.timer_zero_low_byte = st0[7:0];
      if (!split0)
        s_nxt.timer_zero_high_byte = st0[15:8];
    end
    if (inc0h)
      s_nxt.timer_zero_high_byte = hi0;
    if (inc1)
    begin
      s_nxt.timer_one_low_byte  = st1[7:0];
      s_nxt.timer_one_high_byte = st1[15:8];
    end

    set_tf0 = ovf0;
    set_tf1 = split0 ? ovf0h : ovf1;

    ////////////////////////////////////////////////////////////////////////
    // Timer 2
    baud = s_r.timer2_control[TTCU_T2_RCLK] | s_r.timer2_control[TTCU_T2_TX_BAUD_SELECT] |
           s_r.aux[TTCU_AUX_RX_BAUD_SELECT_SECOND_PORT] | s_r.aux[TTCU_AUX_TX_BAUD_SELECT_SECOND_PORT];
    ev2  = s_r.timer2_control[TTCU_T2_CT2] ?
           (s_r.pin2_q & ~count_pin_two) : 1'b1;
    inc2 = tick & s_r.timer2_control[TTCU_T2_TR2] & ev2;
    trig_edge = tick & s_r.trig_q & ~trigger_pin_two;
    ext_ev    = trig_edge & s_r.timer2_control[TTCU_T2_TRIGGER_ENABLE_TWO];
    cnt2      = {s_r.count_high_byte_two, s_r.count_low_byte_two};
    cap       = {s_r.capture_reload_high, s_r.capture_reload_low};
    cnt2_nxt  = cnt2;
    cap_nxt   = cap;
    set_tf2   = 1'b0;
    set_trigger_flag_two  = 1'b0;
    ovf2      = 1'b0;

    if (baud)
    begin
      // Select bit ignored: reload on overflow, no overflow flag
      if (inc2)
      begin
        ovf2     = (cnt2 == TTCU_WORD_ONES);
        cnt2_nxt = ovf2 ? cap : cnt2 + 16'h0001;
      end
      set_trigger_flag_two = ext_ev;
    end
    else if (s_r.timer2_control[TTCU_T2_CPRL2])
    begin
      if (inc2)
      begin
        ovf2     = (cnt2 == TTCU_WORD_ONES);
        cnt2_nxt = cnt2 + 16'h0001;
        set_tf2  = ovf2;
      end
      if (ext_ev)
      begin
        cap_nxt  = cnt2;
        set_trigger_flag_two = 1'b1;
      end
    end
    else if (s_r.aux[TTCU_AUX_DCEN])
    begin
      if (inc2)
      begin
        if (trigger_pin_two)
        begin
          ovf2     = (cnt2 == TTCU_WORD_ONES);
          cnt2_nxt = ovf2 ? cap : cnt2 + 16'h0001;
        end
        else
        begin
          ovf2     = (cnt2 == cap);
          cnt2_nxt = ovf2 ? TTCU_WORD_ONES : cnt2 - 16'h0001;
        end
        set_tf2 = ovf2;
      end
    end
    else
    begin
      if (inc2)
      begin
        ovf2     = (cnt2 == TTCU_WORD_ONES);
        cnt2_nxt = ovf2 ? cap : cnt2 + 16'h0001;
        set_tf2  = ovf2;
      end
      if (ext_ev)
      begin
        cnt2_nxt = cap;
        set_trigger_flag_two = 1'b1;
      end
    end

    s_nxt.count_low_byte_two  = cnt2_nxt[7:0];
    s_nxt.count_high_byte_two = cnt2_nxt[15:8];
    s_nxt.capture_reload_low  = cap_nxt[7:0];
    s_nxt.capture_reload_high = cap_nxt[15:8];
    s_nxt.t1_ovf = ovf1;
    s_nxt.t2_ovf = ovf2;

    ////////////////////////////////////////////////////////////////////////
    // Register writes; a write to a count byte wins over counting
    if (wr)
    begin
      if (ttcu_hit(reg_addr, TTCU_ADDR_MODE_SEL))
        s_nxt.timer01_mode_select = reg_wdata;
      if (ttcu_hit(reg_addr, TTCU_ADDR_RUN_FLAGS))
        s_nxt.run_flags = reg_wdata & TTCU_RF_MASK;
      if (ttcu_hit(reg_addr, TTCU_ADDR_T0_LOW))
        s_nxt.timer_zero_low_byte = reg_wdata;
      if (ttcu_hit(reg_addr, TTCU_ADDR_T0_HIGH))
        s_nxt.timer_zero_high_byte = reg_wdata;
      if (ttcu_hit(reg_addr, TTCU_ADDR_T1_LOW))
        s_nxt.timer_one_low_byte = reg_wdata;
      if (ttcu_hit(reg_addr, TTCU_ADDR_T1_HIGH))
        s_nxt.timer_one_high_byte = reg_wdata;
      if (ttcu_hit(reg_addr, TTCU_ADDR_T2_CTRL))
        s_nxt.timer2_control = reg_wdata;
      if (ttcu_hit(reg_addr, TTCU_ADDR_T2_LOW))
        s_nxt.count_low_byte_two = reg_wdata;
      if (ttcu_hit(reg_addr, TTCU_ADDR_T2_HIGH))
        s_nxt.count_high_byte_two = reg_wdata;
      if (ttcu_hit(reg_addr, TTCU_ADDR_CAP_LOW))
        s_nxt.capture_reload_low = reg_wdata;
      if (ttcu_hit(reg_addr, TTCU_ADDR_CAP_HIGH))
        s_nxt.capture_reload_high = reg_wdata;
      if (ttcu_hit(reg_addr, TTCU_ADDR_AUX))
        s_nxt.aux = reg_wdata & TTCU_AUX_MASK;
    end

    // Hardware set of a flag wins over a software clear in the same cycle
    if (set_tf0)
      s_nxt.run_flags[TTCU_RF_TF0] = 1'b1;
    if (set_tf1)
      s_nxt.run_flags[TTCU_RF_TF1] = 1'b1;
    if (set_tf2)
      s_nxt.timer2_control[TTCU_T2_TF2] = 1'b1;
    if (set_trigger_flag_two)
      s_nxt.timer2_control[TTCU_T2_TRIGGER_FLAG_TWO] = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Read data, valid the cycle after the strobe
    s_nxt.rdata = TTCU_RESET_BYTE;
    if (reg_rd)
    begin
      case (reg_addr)
        TTCU_ADDR_MODE_SEL:  s_nxt.rdata = s_r.timer01_mode_select;
        TTCU_ADDR_RUN_FLAGS: s_nxt.rdata = s_r.run_flags;
        TTCU_ADDR_T0_LOW:    s_nxt.rdata = s_r.timer_zero_low_byte;
        TTCU_ADDR_T0_HIGH:   s_nxt.rdata = s_r.timer_zero_high_byte;
        TTCU_ADDR_T1_LOW:    s_nxt.rdata = s_r.timer_one_low_byte;
        TTCU_ADDR_T1_HIGH:   s_nxt.rdata = s_r.timer_one_high_byte;
        TTCU_ADDR_T2_CTRL:   s_nxt.rdata = s_r.timer2_control;
        TTCU_ADDR_T2_LOW:    s_nxt.rdata = s_r.count_low_byte_two;
        TTCU_ADDR_T2_HIGH:   s_nxt.rdata = s_r.count_high_byte_two;
        TTCU_ADDR_CAP_LOW:   s_nxt.rdata = s_r.capture_reload_low;
        TTCU_ADDR_CAP_HIGH:  s_nxt.rdata = s_r.capture_reload_high;
        TTCU_ADDR_AUX:       s_nxt.rdata = s_r.aux;
        default:             s_nxt.rdata = TTCU_RESET_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata                = s_r.rdata;
  assign overflow_flag_timer_zero = s_r.run_flags[TTCU_RF_TF0];
  assign overflow_flag_timer_one  = s_r.run_flags[TTCU_RF_TF1];
  assign overflow_flag_two        = s_r.timer2_control[TTCU_T2_TF2];
  assign trigger_flag_two         = s_r.timer2_control[TTCU_T2_TRIGGER_FLAG_TWO];
  assign timer2_irq               = s_r.timer2_control[TTCU_T2_TF2] |
                                    s_r.timer2_control[TTCU_T2_TRIGGER_FLAG_TWO];
  assign t1_ovf_pulse             = s_r.t1_ovf;
  assign t2_ovf_pulse             = s_r.t2_ovf;

endmodule // ttcu_timers

// file: pkg/ttcu_pkg.sv
package ttcu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register word indices on the plain register port
  localparam logic [3:0] TTCU_ADDR_MODE_SEL  = 4'h0;
  localparam logic [3:0] TTCU_ADDR_RUN_FLAGS = 4'h1;
  localparam logic [3:0] TTCU_ADDR_T0_LOW    = 4'h2;
  localparam logic [3:0] TTCU_ADDR_T0_HIGH   = 4'h3;
  localparam logic [3:0] TTCU_ADDR_T1_LOW    = 4'h4;
  localparam logic [3:0] TTCU_ADDR_T1_HIGH   = 4'h5;
  localparam logic [3:0] TTCU_ADDR_T2_CTRL   = 4'h6;
  localparam logic [3:0] TTCU_ADDR_T2_LOW    = 4'h7;
  localparam logic [3:0] TTCU_ADDR_T2_HIGH   = 4'h8;
  localparam logic [3:0] TTCU_ADDR_CAP_LOW   = 4'h9;
  localparam logic [3:0] TTCU_ADDR_CAP_HIGH  = 4'hA;
  localparam logic [3:0] TTCU_ADDR_AUX       = 4'hB;

  ////////////////////////////////////////////////////////////////////////////
  // Mode select fields
  localparam int unsigned TTCU_MS_GATE1 = 7;
  localparam int unsigned TTCU_MS_CT1   = 6;
  localparam int unsigned TTCU_MS_MODE1 = 4;
  localparam int unsigned TTCU_MS_GATE0 = 3;
  localparam int unsigned TTCU_MS_CT0   = 2;
  localparam int unsigned TTCU_MS_MODE0 = 0;

  // Run and flag register of timers 0 and 1
  localparam int unsigned TTCU_RF_TF1 = 7;
  localparam int unsigned TTCU_RF_TR1 = 6;
  localparam int unsigned TTCU_RF_TF0 = 5;
  localparam int unsigned TTCU_RF_TR0 = 4;

  // Timer 2 control
  localparam int unsigned TTCU_T2_TF2   = 7;
  localparam int unsigned TTCU_T2_TRIGGER_FLAG_TWO  = 6;
  localparam int unsigned TTCU_T2_RCLK  = 5;
  localparam int unsigned TTCU_T2_TX_BAUD_SELECT  = 4;
  localparam int unsigned TTCU_T2_TRIGGER_ENABLE_TWO = 3;
  localparam int unsigned TTCU_T2_TR2   = 2;
  localparam int unsigned TTCU_T2_CT2   = 1;
  localparam int unsigned TTCU_T2_CPRL2 = 0;

  // Auxiliary register
  localparam int unsigned TTCU_AUX_DCEN = 0;
  localparam int unsigned TTCU_AUX_RX_BAUD_SELECT_SECOND_PORT = 1;
  localparam int unsigned TTCU_AUX_TX_BAUD_SELECT_SECOND_PORT = 2;
  localparam logic [7:0]  TTCU_AUX_MASK  = 8'h07;
  localparam logic [7:0]  TTCU_RF_MASK   = 8'hF0;

  ////////////////////////////////////////////////////////////////////////////
  // Values and timing
  localparam logic [7:0]  TTCU_RESET_BYTE  = 8'h00;
  localparam logic [7:0]  TTCU_BYTE_ONES   = 8'hFF;
  localparam logic [15:0] TTCU_WORD_ONES   = 16'hFFFF;
  localparam logic [4:0]  TTCU_PRESC_ONES  = 5'h1F;
  localparam int unsigned TTCU_PRESC_W     = 5;
  localparam int unsigned TTCU_MC_DIV_DEF  = 12;
  localparam int unsigned TTCU_MC_CNT_W    = 5;

  typedef enum logic [1:0] {
    TTCU_MODE_13BIT  = 2'b00,
    TTCU_MODE_16BIT  = 2'b01,
    TTCU_MODE_RELOAD = 2'b10,
    TTCU_MODE_SPLIT  = 2'b11
  } ttcu_mode_t;

endpackage

// file: test/ttcu_timers_properties.sv
`timescale 1ns/1ps
module ttcu_timers_properties
  import ttcu_pkg::*;
#(
  parameter int unsigned MC_DIV = TTCU_MC_DIV_DEF
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       overflow_flag_timer_zero,
  input wire logic       overflow_flag_timer_one,
  input wire logic       overflow_flag_two,
  input wire logic       trigger_flag_two,
  input wire logic       timer2_irq,
  input wire logic       t1_ovf_pulse,
  input wire logic       t2_ovf_pulse
);
  logic [TTCU_MC_CNT_W-1:0] mc_r;
  logic [3:0]               baud_r;
  logic                     tick;
  logic                     wr_rf;
  logic                     wr_t2;
  assign tick  = (mc_r == TTCU_MC_CNT_W'(MC_DIV - 1));
  assign wr_rf = reg_wr && (reg_addr == TTCU_ADDR_RUN_FLAGS);
  assign wr_t2 = reg_wr && (reg_addr == TTCU_ADDR_T2_CTRL);
  // Shadow of the machine-cycle divider and of the baud selects
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mc_r   <= '0;
      baud_r <= '0;
    end
    else
    begin
      mc_r <= tick ? '0 : mc_r + 1'b1;
      if (wr_t2)
        baud_r[1:0] <= reg_wdata[5:4];
      if (reg_wr && (reg_addr == TTCU_ADDR_AUX))
        baud_r[3:2] <= reg_wdata[2:1];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_irq_or;
    timer2_irq == (overflow_flag_two || trigger_flag_two);
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("timer 2 request wrong");
  property p_t2_tick;
    t2_ovf_pulse |-> $past(tick);
  endproperty
  a_t2_tick: assert property (p_t2_tick) else $error("timer 2 pulse off tick");
  property p_t1_tick;
    t1_ovf_pulse |-> $past(tick) ##1 !t1_ovf_pulse;
  endproperty
  a_t1_tick: assert property (p_t1_tick) else $error("timer 1 pulse wrong");
  property p_tf0_rise;
    $rose(overflow_flag_timer_zero) |-> $past(tick) || $past(wr_rf);
  endproperty
  a_tf0_rise: assert property (p_tf0_rise) else $error("timer 0 flag off tick");
  property p_tf01_fall;
    $fell(overflow_flag_timer_zero) || $fell(overflow_flag_timer_one) |-> $past(wr_rf);
  endproperty
  a_tf01_fall: assert property (p_tf01_fall) else $error("flag cleared by itself");
  property p_tf2_rise;
    $rose(overflow_flag_two) |-> t2_ovf_pulse || $past(wr_t2);
  endproperty
  a_tf2_rise: assert property (p_tf2_rise) else $error("timer 2 flag no pulse");
  property p_tf2_fall;
    $fell(overflow_flag_two) |-> $past(wr_t2);
  endproperty
  a_tf2_fall: assert property (p_tf2_fall) else $error("timer 2 flag self clear");
  property p_baud;
    $rose(overflow_flag_two) |-> !$past(|baud_r) || $past(wr_t2);
  endproperty
  a_baud: assert property (p_baud) else $error("overflow flag in baud mode");
  property p_trigger_flag_two_rise;
    $rose(trigger_flag_two) |-> $past(tick) || $past(wr_t2);
  endproperty
  a_trigger_flag_two_rise: assert property (p_trigger_flag_two_rise) else $error("trigger flag off tick");
  property p_trigger_flag_two_fall;
    $fell(trigger_flag_two) |-> $past(wr_t2);
  endproperty
  a_trigger_flag_two_fall: assert property (p_trigger_flag_two_fall) else $error("trigger flag self clear");
endmodule // ttcu_timers_properties

bind ttcu_timers ttcu_timers_properties #(.MC_DIV(MC_DIV)) u_props (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .overflow_flag_timer_zero(overflow_flag_timer_zero),
  .overflow_flag_timer_one(overflow_flag_timer_one), .overflow_flag_two(overflow_flag_two),
  .trigger_flag_two(trigger_flag_two), .timer2_irq(timer2_irq),
  .t1_ovf_pulse(t1_ovf_pulse), .t2_ovf_pulse(t2_ovf_pulse)
);

// file: test/ttcu_pin_model.sv
`timescale 1ns/1ps
module ttcu_pin_model #(
  parameter int unsigned MC_DIV = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      count_pin_zero,
  output logic      count_pin_one,
  output logic      count_pin_two,
  output logic      trigger_pin_two,
  output logic      ext_irq_pin_zero,
  output logic      ext_irq_pin_one
);
  logic [3:0]  edge_r = 4'hF;
  logic [1:0]  gate_r = 2'h0;
  int unsigned mc_r;
  assign {trigger_pin_two, count_pin_two, count_pin_one, count_pin_zero} = edge_r;
  assign {ext_irq_pin_one, ext_irq_pin_zero} = gate_r;
  // Copy of the machine-cycle divider, so gate windows land on ticks
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mc_r <= 0;
    else
      mc_r <= (mc_r == MC_DIV - 1) ? 0 : mc_r + 1;
  end
  // Returns at the edge just before a tick
  task automatic sync_tick();
    do
      @(posedge clk);
    while (mc_r != MC_DIV - 2);
  endtask
  task automatic gate_ticks(input int which, input int n);
    sync_tick();
    gate_r[which] <= 1'b1;
    repeat (n * MC_DIV) @(posedge clk);
    gate_r[which] <= 1'b0;
  endtask
  task automatic set_level(input int which, input logic lvl);
    edge_r[which] <= lvl;
    repeat (MC_DIV) @(posedge clk);
  endtask
  // Each level is held one machine cycle so one tick samples it
  task automatic pulses(input int which, input int n);
    repeat (n)
    begin
      set_level(which, 1'b0);
      set_level(which, 1'b1);
    end
  endtask
endmodule // ttcu_pin_model

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench
  import ttcu_pkg::*;
;
  localparam int unsigned MC_DIV = 2;
  localparam int          LIMIT  = 5000;
  logic       clk;
  logic       rst_n;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       cp0, cp1, cp2, gp0, gp1, trg;
  logic       tf0, tf1, tf2, xf2, irq2;
  logic [7:0] v;
  int         errors = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  logic [7:0] baud_ctl [4] = '{8'h27, 8'h17, 8'h07, 8'h07};
  logic [7:0] baud_aux [4] = '{8'h00, 8'h00, 8'h02, 8'h04};
  ttcu_timers #(.MC_DIV(MC_DIV)) dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_pin_zero(cp0), .count_pin_one(cp1),
    .count_pin_two(cp2), .ext_irq_pin_zero(gp0), .ext_irq_pin_one(gp1),
    .trigger_pin_two(trg), .overflow_flag_timer_zero(tf0), .overflow_flag_timer_one(tf1),
    .overflow_flag_two(tf2), .trigger_flag_two(xf2), .timer2_irq(irq2),
    .t1_ovf_pulse(), .t2_ovf_pulse()
  );
  ttcu_pin_model #(.MC_DIV(MC_DIV)) pm (
    .clk(clk), .rst_n(rst_n), .count_pin_zero(cp0), .count_pin_one(cp1),
    .count_pin_two(cp2), .trigger_pin_two(trg), .ext_irq_pin_zero(gp0), .ext_irq_pin_one(gp1)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    q = reg_rdata;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] q;
    rd(a, q);
    check(q, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      errors++;
      test_done();
    end
  end
  initial
  begin
    rst_n     = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(TTCU_ADDR_MODE_SEL, 8'h00);
    rd_chk(TTCU_ADDR_T2_CTRL, 8'h00);
    wr(4'hC, 8'hFF);
    rd_chk(4'hC, 8'h00);
    // Timer 0, 16-bit, gated
    wr(TTCU_ADDR_MODE_SEL, 8'h09);
    wr(TTCU_ADDR_T0_LOW, 8'hFE);
    wr(TTCU_ADDR_T0_HIGH, 8'hFF);
    wr(TTCU_ADDR_RUN_FLAGS, 8'h10);
    rd_chk(TTCU_ADDR_T0_LOW, 8'hFE);
    rd_chk(TTCU_ADDR_T0_HIGH, 8'hFF);
    pm.gate_ticks(0, 3);
    rd_chk(TTCU_ADDR_T0_LOW, 8'h01);
    rd_chk(TTCU_ADDR_T0_HIGH, 8'h00);
    rd_chk(TTCU_ADDR_RUN_FLAGS, 8'h30);
    check({7'h00, tf0}, 8'h01);
    // Timer 0, 13-bit prescaler carry
    wr(TTCU_ADDR_MODE_SEL, 8'h08);
    wr(TTCU_ADDR_RUN_FLAGS, 8'h10);
    wr(TTCU_ADDR_T0_LOW, 8'hFF);
    wr(TTCU_ADDR_T0_HIGH, 8'h05);
    pm.gate_ticks(0, 1);
    rd(TTCU_ADDR_T0_LOW, v);
    check(v & 8'h1F, 8'h00);
    rd_chk(TTCU_ADDR_T0_HIGH, 8'h06);
    // Timer 1, 8-bit reload counter, then gated off
    wr(TTCU_ADDR_RUN_FLAGS, 8'h00);
    wr(TTCU_ADDR_MODE_SEL, 8'h60);
    wr(TTCU_ADDR_T1_HIGH, 8'hF0);
    wr(TTCU_ADDR_T1_LOW, 8'hFE);
    wr(TTCU_ADDR_RUN_FLAGS, 8'h40);
    pm.pulses(1, 3);
    rd_chk(TTCU_ADDR_T1_LOW, 8'hF1);
    rd_chk(TTCU_ADDR_T1_HIGH, 8'hF0);
    rd_chk(TTCU_ADDR_RUN_FLAGS, 8'hC0);
    wr(TTCU_ADDR_MODE_SEL, 8'hE0);
    pm.pulses(1, 2);
    rd_chk(TTCU_ADDR_T1_LOW, 8'hF1);
    // Timer 0 split, timer 1 held
    wr(TTCU_ADDR_RUN_FLAGS, 8'h00);
    wr(TTCU_ADDR_MODE_SEL, 8'h33);
    wr(TTCU_ADDR_T0_HIGH, 8'hFE);
    wr(TTCU_ADDR_T0_LOW, 8'h10);
    pm.sync_tick();
    wr(TTCU_ADDR_RUN_FLAGS, 8'h40);
    repeat (3 * MC_DIV - 2) @(posedge clk);
    check({7'h00, tf1}, 8'h01);
    wr(TTCU_ADDR_RUN_FLAGS, 8'h00);
    rd_chk(TTCU_ADDR_T0_HIGH, 8'h01);
    rd_chk(TTCU_ADDR_T0_LOW, 8'h10);
    rd_chk(TTCU_ADDR_T1_LOW, 8'hF1);
    // Timer 2 capture mode, counter input
    wr(TTCU_ADDR_T2_LOW, 8'hFE);
    wr(TTCU_ADDR_T2_HIGH, 8'hFF);
    wr(TTCU_ADDR_T2_CTRL, 8'h07);
    pm.pulses(2, 3);
    rd_chk(TTCU_ADDR_T2_LOW, 8'h01);
    rd_chk(TTCU_ADDR_T2_HIGH, 8'h00);
    rd_chk(TTCU_ADDR_T2_CTRL, 8'h87);
    check({7'h00, irq2}, 8'h01);
    wr(TTCU_ADDR_T2_CTRL, 8'h03);
    pm.pulses(2, 2);
    rd_chk(TTCU_ADDR_T2_LOW, 8'h01);
    wr(TTCU_ADDR_T2_CTRL, 8'h0F);
    pm.pulses(3, 1);
    rd_chk(TTCU_ADDR_CAP_LOW, 8'h01);
    rd_chk(TTCU_ADDR_T2_CTRL, 8'h4F);
    check({7'h00, xf2}, 8'h01);
    // Timer 2 auto-reload on rollover and on trigger edge
    wr(TTCU_ADDR_CAP_LOW, 8'h34);
    wr(TTCU_ADDR_CAP_HIGH, 8'h12);
    wr(TTCU_ADDR_T2_LOW, 8'hFF);
    wr(TTCU_ADDR_T2_HIGH, 8'hFF);
    wr(TTCU_ADDR_T2_CTRL, 8'h06);
    pm.pulses(2, 1);
    rd_chk(TTCU_ADDR_T2_HIGH, 8'h12);
    rd_chk(TTCU_ADDR_T2_CTRL, 8'h86);
    wr(TTCU_ADDR_T2_LOW, 8'h55);
    wr(TTCU_ADDR_T2_CTRL, 8'h0E);
    pm.pulses(3, 1);
    rd_chk(TTCU_ADDR_T2_LOW, 8'h34);
    rd_chk(TTCU_ADDR_T2_CTRL, 8'h4E);
    // Down count to the reload value and past it
    wr(TTCU_ADDR_AUX, 8'h01);
    wr(TTCU_ADDR_T2_LOW, 8'h36);
    wr(TTCU_ADDR_T2_CTRL, 8'h06);
    pm.set_level(3, 1'b0);
    pm.pulses(2, 3);
    rd_chk(TTCU_ADDR_T2_HIGH, 8'hFF);
    rd_chk(TTCU_ADDR_T2_CTRL, 8'h86);
    pm.set_level(3, 1'b1);
    // Every baud select reloads without raising the flag
    for (int i = 0; i < 4; i++)
    begin
      wr(TTCU_ADDR_AUX, baud_aux[i]);
      wr(TTCU_ADDR_T2_LOW, 8'hFF);
      wr(TTCU_ADDR_T2_HIGH, 8'hFF);
      wr(TTCU_ADDR_T2_CTRL, baud_ctl[i]);
      pm.pulses(2, 1);
      rd_chk(TTCU_ADDR_T2_LOW, 8'h34);
      rd_chk(TTCU_ADDR_T2_CTRL, baud_ctl[i]);
    end
    // Timer 2 timer function in baud mode, trigger edge as extra request
    wr(TTCU_ADDR_T2_LOW, 8'hFE);
    wr(TTCU_ADDR_T2_HIGH, 8'hFF);
    pm.sync_tick();
    wr(TTCU_ADDR_T2_CTRL, 8'h2C);
    repeat (3 * MC_DIV - 2) @(posedge clk);
    wr(TTCU_ADDR_T2_CTRL, 8'h28);
    rd_chk(TTCU_ADDR_T2_LOW, 8'h35);
    rd_chk(TTCU_ADDR_T2_HIGH, 8'h12);
    pm.pulses(3, 1);
    rd_chk(TTCU_ADDR_T2_LOW, 8'h35);
    rd_chk(TTCU_ADDR_T2_CTRL, 8'h68);
    check({7'h00, irq2}, 8'h01);
    // Timer 0 counter function, 8-bit reload
    wr(TTCU_ADDR_MODE_SEL, 8'h06);
    wr(TTCU_ADDR_T0_HIGH, 8'h80);
    wr(TTCU_ADDR_T0_LOW, 8'hFF);
    wr(TTCU_ADDR_RUN_FLAGS, 8'h10);
    pm.pulses(0, 1);
    rd_chk(TTCU_ADDR_T0_LOW, 8'h80);
    rd_chk(TTCU_ADDR_RUN_FLAGS, 8'h30);
    test_done();
  end
endmodule // testbench
